// ==== logic/ihp_regs.vh ====
// register map and fixed constants of the i2c host port
`ifndef IHP_REGS_VH
`define IHP_REGS_VH

// =====================================================
// bus addressing
`define IHP_ADDR_HIGH6    6'h2e
`define IHP_NUM_REGS      37
`define IHP_LAST_OFFSET   8'h24

// =====================================================
// register offsets
`define IHP_CHIP_REVISION_ID_OFS          8'h00
`define IHP_LINE_PLL_DIVIDER_HIGH_OFS     8'h01
`define IHP_LINE_PLL_DIVIDER_LOW_OFS      8'h02
`define IHP_LINE_PLL_CONTROL_OFS          8'h03
`define IHP_LINE_PLL_PHASE_SELECT_OFS     8'h04
`define IHP_CLAMP_START_POSITION_OFS      8'h05
`define IHP_CLAMP_PULSE_WIDTH_OFS         8'h06
`define IHP_HSYNC_OUT_WIDTH_OFS           8'h07
`define IHP_BLUE_FINE_GAIN_OFS            8'h08
`define IHP_GREEN_FINE_GAIN_OFS           8'h09
`define IHP_RED_FINE_GAIN_OFS             8'h0a
`define IHP_BLUE_FINE_OFFSET_HIGH_OFS     8'h0b
`define IHP_GREEN_FINE_OFFSET_HIGH_OFS    8'h0c
`define IHP_RED_FINE_OFFSET_HIGH_OFS      8'h0d
`define IHP_SYNC_CONTROL_FIRST_OFS        8'h0e
`define IHP_LINE_PLL_CLAMP_CONTROL_OFS    8'h0f
`define IHP_GREEN_SYNC_THRESHOLD_OFS      8'h10
`define IHP_SYNC_SEPARATOR_THRESHOLD_OFS  8'h11
`define IHP_LINE_PLL_PRE_COAST_OFS        8'h12
`define IHP_LINE_PLL_POST_COAST_OFS       8'h13
`define IHP_SYNC_DETECT_STATUS_OFS        8'h14
`define IHP_OUTPUT_FORMATTER_CONTROL_OFS  8'h15
`define IHP_GENERAL_CONTROL_1_OFS         8'h16
`define IHP_GENERAL_CONTROL_2_OFS         8'h17
`define IHP_GENERAL_CONTROL_3_OFS         8'h18
`define IHP_INPUT_SELECT_1_OFS            8'h19
`define IHP_INPUT_SELECT_2_OFS            8'h1a
`define IHP_BLUE_GREEN_COARSE_GAIN_OFS    8'h1b
`define IHP_RED_COARSE_GAIN_OFS           8'h1c
`define IHP_FINE_OFFSET_LOW_BITS_OFS      8'h1d
`define IHP_BLUE_COARSE_OFFSET_OFS        8'h1e
`define IHP_GREEN_COARSE_OFFSET_OFS       8'h1f
`define IHP_RED_COARSE_OFFSET_OFS         8'h20
`define IHP_HSYNC_OUT_START_OFS           8'h21
`define IHP_GENERAL_CONTROL_4_OFS         8'h22
`define IHP_BLUE_LEVEL_RESULT_LOW_OFS     8'h23
`define IHP_GREEN_LEVEL_RESULT_LOW_OFS    8'h24

// =====================================================
// field positions
`define IHP_PIXEL_OE_BIT        0
`define IHP_GREEN_SYNC_OE_BIT   1

// =====================================================
// reset values
`define IHP_LINE_PLL_DIVIDER_HIGH_RST     8'h67
`define IHP_LINE_PLL_DIVIDER_LOW_RST      8'h20
`define IHP_LINE_PLL_CONTROL_RST          8'ha8
`define IHP_LINE_PLL_PHASE_SELECT_RST     8'h80
`define IHP_CLAMP_START_POSITION_RST      8'h32
`define IHP_CLAMP_PULSE_WIDTH_RST         8'h20
`define IHP_HSYNC_OUT_WIDTH_RST           8'h20
`define IHP_BLUE_FINE_GAIN_RST            8'h00
`define IHP_GREEN_FINE_GAIN_RST           8'h00
`define IHP_RED_FINE_GAIN_RST             8'h00
`define IHP_BLUE_FINE_OFFSET_HIGH_RST     8'h80
`define IHP_GREEN_FINE_OFFSET_HIGH_RST    8'h80
`define IHP_RED_FINE_OFFSET_HIGH_RST      8'h80
`define IHP_SYNC_CONTROL_FIRST_RST        8'h5b
`define IHP_LINE_PLL_CLAMP_CONTROL_RST    8'h2e
`define IHP_GREEN_SYNC_THRESHOLD_RST      8'h5d
`define IHP_SYNC_SEPARATOR_THRESHOLD_RST  8'h20
`define IHP_LINE_PLL_PRE_COAST_RST        8'h00
`define IHP_LINE_PLL_POST_COAST_RST       8'h00
`define IHP_OUTPUT_FORMATTER_CONTROL_RST  8'h04
`define IHP_GENERAL_CONTROL_1_RST         8'h11
`define IHP_GENERAL_CONTROL_2_RST         8'h03
`define IHP_GENERAL_CONTROL_3_RST         8'h00
`define IHP_INPUT_SELECT_1_RST            8'h00
`define IHP_INPUT_SELECT_2_RST            8'hc2
`define IHP_BLUE_GREEN_COARSE_GAIN_RST    8'h77
`define IHP_RED_COARSE_GAIN_RST           8'h07
`define IHP_FINE_OFFSET_LOW_BITS_RST      8'h00
`define IHP_BLUE_COARSE_OFFSET_RST        8'h10
`define IHP_GREEN_COARSE_OFFSET_RST       8'h10
`define IHP_RED_COARSE_OFFSET_RST         8'h10
`define IHP_HSYNC_OUT_START_RST           8'h0d
`define IHP_GENERAL_CONTROL_4_RST         8'h08

`endif

// ==== logic/ihp_host_port.v ====
// i2c slave host port with its control register bank
// =====================================================
`include "ihp_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module ihp_host_port #(
  parameter [7:0] REVISION = 8'h5a  // arbitrary value
) (
  // clock and reset
  input  wire       CLK_SYS,
  input  wire       RST_N,
  // i2c pins
  input  wire       SCL_IN,
  input  wire       SDA_IN,
  output reg        SDA_OUT,
  output reg        SDA_OE,
  // address select strap
  input  wire       ADDRESS_SELECT_STRAP,
  // device status
  input  wire [7:0] SYNC_DETECT_STATUS,
  input  wire [7:0] BLUE_LEVEL_RESULT,
  input  wire [7:0] GREEN_LEVEL_RESULT,
  // output enables
  output reg        PIXEL_SYNC_CLOCK_OE,
  output reg        GREEN_SYNC_OUTPUT_OE
);

  // =====================================================
  // states
  localparam [3:0] ST_IDLE    = 4'h0;
  localparam [3:0] ST_DEVADDR = 4'h1;
  localparam [3:0] ST_ACK_DEV = 4'h2;
  localparam [3:0] ST_SUBADDR = 4'h3;
  localparam [3:0] ST_ACK_SUB = 4'h4;
  localparam [3:0] ST_WDATA   = 4'h5;
  localparam [3:0] ST_ACK_WR  = 4'h6;
  localparam [3:0] ST_RDATA   = 4'h7;
  localparam [3:0] ST_RACK    = 4'h8;

  localparam integer NREG = `IHP_NUM_REGS;

  // =====================================================
  // default table
  function [7:0] reg_default;
    input integer idx;
    begin
      case (idx)
        1:  reg_default = `IHP_LINE_PLL_DIVIDER_HIGH_RST;
        2:  reg_default = `IHP_LINE_PLL_DIVIDER_LOW_RST;
        3:  reg_default = `IHP_LINE_PLL_CONTROL_RST;
        4:  reg_default = `IHP_LINE_PLL_PHASE_SELECT_RST;
        5:  reg_default = `IHP_CLAMP_START_POSITION_RST;
        6:  reg_default = `IHP_CLAMP_PULSE_WIDTH_RST;
        7:  reg_default = `IHP_HSYNC_OUT_WIDTH_RST;
        8:  reg_default = `IHP_BLUE_FINE_GAIN_RST;
        9:  reg_default = `IHP_GREEN_FINE_GAIN_RST;
        10: reg_default = `IHP_RED_FINE_GAIN_RST;
        11: reg_default = `IHP_BLUE_FINE_OFFSET_HIGH_RST;
        12: reg_default = `IHP_GREEN_FINE_OFFSET_HIGH_RST;
        13: reg_default = `IHP_RED_FINE_OFFSET_HIGH_RST;
        14: reg_default = `IHP_SYNC_CONTROL_FIRST_RST;
        15: reg_default = `IHP_LINE_PLL_CLAMP_CONTROL_RST;
        16: reg_default = `IHP_GREEN_SYNC_THRESHOLD_RST;
        17: reg_default = `IHP_SYNC_SEPARATOR_THRESHOLD_RST;
        18: reg_default = `IHP_LINE_PLL_PRE_COAST_RST;
        19: reg_default = `IHP_LINE_PLL_POST_COAST_RST;
        21: reg_default = `IHP_OUTPUT_FORMATTER_CONTROL_RST;
        22: reg_default = `IHP_GENERAL_CONTROL_1_RST;
        23: reg_default = `IHP_GENERAL_CONTROL_2_RST;
        24: reg_default = `IHP_GENERAL_CONTROL_3_RST;
        25: reg_default = `IHP_INPUT_SELECT_1_RST;
        26: reg_default = `IHP_INPUT_SELECT_2_RST;
        27: reg_default = `IHP_BLUE_GREEN_COARSE_GAIN_RST;
        28: reg_default = `IHP_RED_COARSE_GAIN_RST;
        29: reg_default = `IHP_FINE_OFFSET_LOW_BITS_RST;
        30: reg_default = `IHP_BLUE_COARSE_OFFSET_RST;
        31: reg_default = `IHP_GREEN_COARSE_OFFSET_RST;
        32: reg_default = `IHP_RED_COARSE_OFFSET_RST;
        33: reg_default = `IHP_HSYNC_OUT_START_RST;
        34: reg_default = `IHP_GENERAL_CONTROL_4_RST;
        default: reg_default = 8'h00;
      endcase
    end
  endfunction

  // read-only locations
  function is_read_only;
    input [7:0] ofs;
    begin
      is_read_only = (ofs == `IHP_CHIP_REVISION_ID_OFS) ||
                     (ofs == `IHP_SYNC_DETECT_STATUS_OFS) ||
                     (ofs == `IHP_BLUE_LEVEL_RESULT_LOW_OFS) ||
                     (ofs == `IHP_GREEN_LEVEL_RESULT_LOW_OFS);
    end
  endfunction

  // =====================================================
  // input synchronisers
  reg  [1:0] scl_sync_reg;
  reg  [1:0] sda_sync_reg;
  reg  [1:0] strap_sync_reg;
  reg        scl_prev_reg;
  reg        sda_prev_reg;

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      scl_sync_reg   <= 2'h3;
      sda_sync_reg   <= 2'h3;
      strap_sync_reg <= 2'h0;
      scl_prev_reg   <= 1'b1;
      sda_prev_reg   <= 1'b1;
    end else begin
      scl_sync_reg   <= {scl_sync_reg[0], SCL_IN};
      sda_sync_reg   <= {sda_sync_reg[0], SDA_IN};
      strap_sync_reg <= {strap_sync_reg[0], ADDRESS_SELECT_STRAP};
      scl_prev_reg   <= scl_sync_reg[1];
      sda_prev_reg   <= sda_sync_reg[1];
    end
  end

  wire scl_s    = scl_sync_reg[1];
  wire sda_s    = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_prev_reg;
  wire scl_fall = ~scl_s & scl_prev_reg;
  wire start_ev = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  wire stop_ev  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // =====================================================
  // transfer state
  reg  [3:0] state_reg;
  reg  [2:0] bit_cnt_reg;
  reg  [7:0] shift_reg;
  reg  [7:0] ptr_reg;
  reg        rd_dir_reg;
  reg        master_ack_reg;

  wire [7:0] byte_in   = {shift_reg[6:0], sda_s};
  wire       byte_last = scl_rise & (bit_cnt_reg == 3'h7);
  wire [6:0] my_addr   = {`IHP_ADDR_HIGH6, strap_sync_reg[1]};
  wire       wr_strobe = byte_last & (state_reg == ST_WDATA);

  // =====================================================
  // register bank
  wire [8*NREG-1:0] bank_flat;

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : g_bank
      reg [7:0] cell_reg;
      always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          cell_reg <= reg_default(gi);
        end else if (wr_strobe && ptr_reg == gi &&
                     !is_read_only(gi)) begin
          cell_reg <= byte_in;
        end
      end
      assign bank_flat[8*gi +: 8] = cell_reg;
    end
  endgenerate

  // read data mux
  reg [7:0] rd_data;

  always @* begin
    rd_data = 8'h00;
    if (ptr_reg <= `IHP_LAST_OFFSET) begin
      rd_data = bank_flat[8*ptr_reg +: 8];
    end
    case (ptr_reg)
      `IHP_CHIP_REVISION_ID_OFS:       rd_data = REVISION;
      `IHP_SYNC_DETECT_STATUS_OFS:     rd_data = SYNC_DETECT_STATUS;
      `IHP_BLUE_LEVEL_RESULT_LOW_OFS:  rd_data = BLUE_LEVEL_RESULT;
      `IHP_GREEN_LEVEL_RESULT_LOW_OFS: rd_data = GREEN_LEVEL_RESULT;
      default: ;
    endcase
  end

  // =====================================================
  // protocol engine
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_reg      <= ST_IDLE;
      bit_cnt_reg    <= 3'h0;
      shift_reg      <= 8'h00;
      ptr_reg        <= 8'h00;
      rd_dir_reg     <= 1'b0;
      master_ack_reg <= 1'b0;
      SDA_OE         <= 1'b0;
      SDA_OUT        <= 1'b0;
    end else if (start_ev) begin
      state_reg   <= ST_DEVADDR;
      bit_cnt_reg <= 3'h0;
      SDA_OE      <= 1'b0;
    end else if (stop_ev) begin
      state_reg <= ST_IDLE;
      SDA_OE    <= 1'b0;
    end else begin
      case (state_reg)
        ST_DEVADDR, ST_SUBADDR, ST_WDATA: begin
          if (scl_rise) begin
            shift_reg   <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
          end
          if (byte_last) begin
            case (state_reg)
              ST_DEVADDR: begin
                rd_dir_reg <= sda_s;
                if (shift_reg[6:0] == my_addr) begin
                  state_reg <= ST_ACK_DEV;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end
              ST_SUBADDR: begin
                ptr_reg   <= byte_in;
                state_reg <= ST_ACK_SUB;
              end
              default: begin
                ptr_reg   <= ptr_reg + 8'h01;
                state_reg <= ST_ACK_WR;
              end
            endcase
          end
        end
        ST_ACK_DEV, ST_ACK_SUB, ST_ACK_WR: begin
          if (scl_fall) begin
            if (!SDA_OE) begin
              SDA_OE <= 1'b1;
            end else if (state_reg == ST_ACK_DEV && rd_dir_reg) begin
              shift_reg   <= rd_data;
              SDA_OE      <= ~rd_data[7];
              bit_cnt_reg <= 3'h0;
              state_reg   <= ST_RDATA;
            end else begin
              SDA_OE      <= 1'b0;
              bit_cnt_reg <= 3'h0;
              state_reg   <= (state_reg == ST_ACK_DEV) ?
                             ST_SUBADDR : ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
          end
          if (scl_fall) begin
            if (bit_cnt_reg == 3'h0) begin
              SDA_OE    <= 1'b0;
              ptr_reg   <= ptr_reg + 8'h01;
              state_reg <= ST_RACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              SDA_OE    <= ~shift_reg[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            master_ack_reg <= ~sda_s;
          end
          if (scl_fall) begin
            if (master_ack_reg) begin
              shift_reg   <= rd_data;
              SDA_OE      <= ~rd_data[7];
              bit_cnt_reg <= 3'h0;
              state_reg   <= ST_RDATA;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_IDLE: begin
          SDA_OE <= 1'b0;
        end
        default: begin
          state_reg <= ST_IDLE;
          SDA_OE    <= 1'b0;
        end
      endcase
    end
  end

  // =====================================================
  // output enables
  wire [7:0] ctrl2 = bank_flat[8*`IHP_GENERAL_CONTROL_2_OFS +: 8];

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      PIXEL_SYNC_CLOCK_OE  <= 1'b0;
      GREEN_SYNC_OUTPUT_OE <= 1'b0;
    end else begin
      PIXEL_SYNC_CLOCK_OE  <= ctrl2[`IHP_PIXEL_OE_BIT];
      GREEN_SYNC_OUTPUT_OE <= ctrl2[`IHP_GREEN_SYNC_OE_BIT];
    end
  end

endmodule

`default_nettype wire

// ==== testbench/ihp_host_port_assertions.sv ====
// concurrent checks on the host port pins
`timescale 1ns/1ns
`default_nettype none
module ihp_host_port_chk (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  // output enables
  input wire logic PIXEL_SYNC_CLOCK_OE,
  input wire logic GREEN_SYNC_OUTPUT_OE
);
  // ========
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_pixel_oe_reset:
    assert property ($rose(RST_N) |-> !PIXEL_SYNC_CLOCK_OE ##1
      PIXEL_SYNC_CLOCK_OE) else $error("pixel enable wrong at reset");
  a_green_oe_reset:
    assert property ($rose(RST_N) |-> !GREEN_SYNC_OUTPUT_OE ##1
      GREEN_SYNC_OUTPUT_OE) else $error("green enable wrong at reset");
  a_sda_reset_idle:
    assert property ($rose(RST_N) |-> !SDA_OE [*3])
    else $error("data driven right after reset");
  a_drive_low_only:
    assert property (SDA_OE |-> !SDA_OUT)
    else $error("data driven high");
  a_sda_steady_high:
    assert property (SCL_IN && $past(SCL_IN, 2) |-> $stable(SDA_OE))
    else $error("data changed while clock high");
  a_ack_full_bit:
    assert property ($rose(SDA_OE) |=> SDA_OE [*6])
    else $error("data drive shorter than a bit");
  a_start_quiet:
    assert property (SCL_IN && $fell(SDA_IN) && !SDA_OE |=> !SDA_OE [*8])
    else $error("data driven during address bits");
  a_stop_quiet:
    assert property (SCL_IN && $rose(SDA_IN) |=> !SDA_OE [*8])
    else $error("data driven after stop");
endmodule
bind ihp_host_port ihp_host_port_chk chk_u (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .PIXEL_SYNC_CLOCK_OE(PIXEL_SYNC_CLOCK_OE),
  .GREEN_SYNC_OUTPUT_OE(GREEN_SYNC_OUTPUT_OE)
);
`default_nettype wire

// ==== testbench/ihp_i2c_master.sv ====
// bus master model for the host port
`timescale 1ns/1ns
`default_nettype none
module ihp_i2c_master (
  // clock
  input  wire logic       clk,
  // bus
  input  wire logic       sda,
  output var  logic       scl,
  output var  logic       sda_low,
  // read results
  output var  logic [7:0] got,
  output var  logic       got_v
);
  // ========
  // idle bus
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    got = 8'h00;
    got_v = 1'b0;
  end
  // ========
  // bit timing, quarter of a 400 ns clock
  task automatic q();
    repeat (2) @(negedge clk);
  endtask
  task automatic bit_io(input logic b, output logic s);
    q();
    sda_low = !b;
    q();
    scl = 1'b1;
    q();
    q();
    s = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    q();
    q();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
  endtask
  task automatic stop();
    q();
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic rd(input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      got[i] = s;
    end
    got_v = 1'b1;
    bit_io(last, s);
    got_v = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/ihp_host_port_test.sv ====
// self-checking bench of the host port
`timescale 1ns/1ns
`default_nettype none
module ihp_host_port_test;
  localparam logic [7:0] REV = 8'h3c; // arbitrary
  logic       clk_sys, rst_n, strap, sda_oe, sda_out, pix_oe, grn_oe;
  logic       scl, sda_low, got_v;
  logic [7:0] sync_st, blue_lv, green_lv, dev, got;
  logic [7:0] wdat [37];
  logic [7:0] exp_q [$];
  int         errors = 0, num_checks = 0, cycles = 0;
  wire        sda = !(sda_low || sda_oe);
  logic [7:0] exp_r [37] = '{8'h00, 8'h67, 8'h20, 8'ha8, 8'h80, 8'h32,
    8'h20, 8'h20, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h5b, 8'h2e,
    8'h5d, 8'h20, 8'h00, 8'h00, 8'h00, 8'h04, 8'h11, 8'h03, 8'h00, 8'h00,
    8'hc2, 8'h77, 8'h07, 8'h00, 8'h10, 8'h10, 8'h10, 8'h0d, 8'h08, 8'h00,
    8'h00};
  // ========
  // design and bus master
  ihp_host_port #(.REVISION(REV)) dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .ADDRESS_SELECT_STRAP(strap), .SYNC_DETECT_STATUS(sync_st),
    .BLUE_LEVEL_RESULT(blue_lv), .GREEN_LEVEL_RESULT(green_lv),
    .PIXEL_SYNC_CLOCK_OE(pix_oe), .GREEN_SYNC_OUTPUT_OE(grn_oe));
  ihp_i2c_master mst_u (.clk(clk_sys), .sda(sda), .scl(scl),
    .sda_low(sda_low), .got(got), .got_v(got_v));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ========
  // helpers
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [7:0] ev(input logic [7:0] i);
    case (i)
      8'h00: ev = REV;
      8'h14: ev = sync_st;
      8'h23: ev = blue_lv;
      8'h24: ev = green_lv;
      default: ev = (i > 8'h24) ? 8'h00 : exp_r[i];
    endcase
  endfunction
  task automatic addr(input logic [7:0] a, input logic e);
    logic k;
    mst_u.start();
    mst_u.wr(a, k);
    chk("adr_ack", {7'h0, k}, {7'h0, e});
  endtask
  task automatic wr_regs(input logic [7:0] o, input int n);
    logic k;
    addr(dev, 1'b1);
    mst_u.wr(o, k);
    chk("sub_ack", {7'h0, k}, 8'h01);
    for (int i = 0; i < n; i++) begin
      mst_u.wr(wdat[o+i], k);
      chk("dat_ack", {7'h0, k}, 8'h01);
      if (!(8'(o + i) inside {8'h00, 8'h14, 8'h23, 8'h24}))
        exp_r[o+i] = wdat[o+i];
    end
    mst_u.stop();
  endtask
  task automatic rd_regs(input logic [7:0] o, input int n);
    logic k;
    addr(dev, 1'b1);
    mst_u.wr(o, k);
    chk("sub_ack", {7'h0, k}, 8'h01);
    addr(dev | 8'h01, 1'b1);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(ev(8'(o + i)));
      mst_u.rd(i == n - 1);
    end
    mst_u.stop();
  endtask
  // ========
  // result monitor and timeout
  initial forever begin
    @(posedge got_v);
    chk("rdata", got, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      report_and_stop();
    end
  end
  // ========
  // scenarios
  initial begin
    void'($urandom(32'hdaff));
    rst_n = 1'b0;
    strap = 1'b0;
    dev = 8'hb8;
    sync_st = 8'($urandom);
    blue_lv = 8'($urandom);
    green_lv = 8'($urandom);
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("pix_oe", {7'h0, pix_oe}, 8'h01);
    chk("grn_oe", {7'h0, grn_oe}, 8'h01);
    rd_regs(8'h00, 37);
    foreach (wdat[i]) wdat[i] = 8'($urandom);
    wdat[2] = wdat[2] & 8'hf0;
    wdat[3] = wdat[3] & 8'hf8;
    wr_regs(8'h00, 37);
    sync_st = 8'($urandom);
    blue_lv = 8'($urandom);
    green_lv = 8'($urandom);
    rd_regs(8'h00, 37);
    for (int v = 0; v < 4; v++) begin
      wdat[8'h17] = 8'(v);
      wr_regs(8'h17, 1);
      chk("pix_oe", {7'h0, pix_oe}, {7'h0, wdat[8'h17][0]});
      chk("grn_oe", {7'h0, grn_oe}, {7'h0, wdat[8'h17][1]});
    end
    rd_regs(8'h22, 4);
    for (int s = 0; s < 2; s++) begin
      strap = s[0];
      dev = {6'h2e, s[0], 1'b0};
      repeat (4) @(negedge clk_sys);
      addr({6'h2e, !s[0], 1'b0}, 1'b0);
      mst_u.stop();
      rd_regs(8'h16, 3);
    end
    chk("pending", 8'(exp_q.size()), 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
